// ---- fcs_pkg.sv ----
// constants for the frequency locked clock system
// assumes an 8-bit register model carried on a 32-bit wishbone slave
package fcs_pkg;

    // ==========================================================
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_INT_LO = 8'h50;
    localparam logic [7:0] IDX_INT_HI = 8'h51;
    localparam logic [7:0] IDX_CTRL   = 8'h52;
    localparam logic [7:0] IDX_CFG    = 8'h53;
    localparam logic [7:0] IDX_MODE   = 8'h54;
    localparam logic [7:0] IDX_STAT   = 8'h55;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_CTRL   = 8'h1f;
    localparam logic [7:0] RST_INT_LO = 8'h40;
    localparam logic [7:0] RST_INT_HI = 8'h00;
    localparam logic [7:0] RST_CFG    = 8'h00;
    localparam logic [7:0] RST_MODE   = 8'h00;

    // ==========================================================
    // field positions
    localparam int CTRL_MOD_DIS = 7;
    localparam int LO_DIV_HI    = 7;
    localparam int LO_DIV_LO    = 6;
    localparam int LO_FN_HI     = 5;
    localparam int LO_FN_LO     = 2;
    localparam int CFG_RANGE    = 0;
    localparam int CFG_SCALE    = 1;
    localparam int CFG_ADIV_LO  = 2;
    localparam int CFG_MDIV_LO  = 4;
    localparam int CFG_X2_DIS   = 6;
    localparam int CFG_SM_OFF   = 7;
    localparam int MODE_CPU_OFF = 0;
    localparam int MODE_X1_OFF  = 1;
    localparam int MODE_LOOP_DIS = 2;
    localparam int MODE_MSEL_LO = 4;
    localparam int MODE_SSEL    = 6;

    // ==========================================================
    // master source codes and tap limits
    localparam logic [1:0] MSEL_SECOND = 2'h2;
    localparam logic [1:0] MSEL_FIRST  = 2'h3;
    localparam logic [4:0] TAP_TOP     = 5'h1c;
    localparam logic [9:0] INT_MAX     = 10'h3ff;

    typedef enum logic [1:0] {
        FCS_DIV1 = 2'b00,
        FCS_DIV2 = 2'b01,
        FCS_DIV4 = 2'b10,
        FCS_DIV8 = 2'b11
    } fcs_div_e;

    // toggle every 2^(sel-1) source edges
    function automatic logic [2:0] fcs_div_mask(input logic [1:0] sel);
        case (sel)
            2'b10:   fcs_div_mask = 3'h1;
            2'b11:   fcs_div_mask = 3'h3;
            default: fcs_div_mask = 3'h0;
        endcase
    endfunction

    // most significant set bit of the range bits wins
    function automatic logic [2:0] fcs_range(input logic [3:0] fn);
        if (fn[3]) fcs_range = 3'h4;
        else if (fn[2]) fcs_range = 3'h3;
        else if (fn[1]) fcs_range = 3'h2;
        else if (fn[0]) fcs_range = 3'h1;
        else fcs_range = 3'h0;
    endfunction

endpackage

// ---- fcs_divider.sv ----
// power-of-two clock divider working on sampled clock levels
// assumes src_rise_i is a one-cycle pulse on each rising source edge
`timescale 1ns/1ps
`default_nettype none
module fcs_divider
    import fcs_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       src_lvl_i,
    input  wire logic       src_rise_i,
    input  wire fcs_div_e   sel_i,
    output logic            clk_o,
    output logic            rise_o
);

    logic [2:0] cnt_ff;
    logic       tgl;

    assign tgl = src_rise_i && ((cnt_ff & fcs_div_mask(sel_i)) == fcs_div_mask(sel_i));

    // ==========================================================
    // edge counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 3'h0;
        end else if (src_rise_i) begin
            cnt_ff <= cnt_ff + 3'h1;
        end
    end

    // ==========================================================
    // divided level and its rising pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_o  <= 1'b0;
            rise_o <= 1'b0;
        end else if (sel_i == FCS_DIV1) begin
            clk_o  <= src_lvl_i;
            rise_o <= src_rise_i;
        end else begin
            clk_o  <= tgl ? !clk_o : clk_o;
            rise_o <= tgl && !clk_o;
        end
    end

endmodule
`default_nettype wire

// ---- fcs_integrator.sv ----
// 10-bit up/down frequency integrator with software load
// assumes step requests arrive at most once per auxiliary period
`timescale 1ns/1ps
`default_nettype none
module fcs_integrator
    import fcs_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       step_i,
    input  wire logic       up_i,
    input  wire logic       hold_i,
    input  wire logic       wr_hi_i,
    input  wire logic       wr_lo_i,
    input  wire logic [7:0] wdata_i,
    output logic      [9:0] value_o
);

    // ==========================================================
    // a software write wins over a step in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            value_o <= {RST_INT_HI, RST_INT_LO[1:0]};
        end else if (wr_hi_i || wr_lo_i) begin
            value_o[9:2] <= wr_hi_i ? wdata_i : value_o[9:2];
            value_o[1:0] <= wr_lo_i ? wdata_i[1:0] : value_o[1:0];
        end else if (step_i && !hold_i) begin
            // saturates so the tap cannot wrap from top to bottom
            if (up_i && value_o != INT_MAX) begin
                value_o <= value_o + 10'h001;
            end else if (!up_i && value_o != 10'h000) begin
                value_o <= value_o - 10'h001;
            end
        end
    end

endmodule
`default_nettype wire

// ---- fcs_top.sv ----
// frequency locked clock system: source selection, dividers and the
// digital loop that holds the ring oscillator at a multiple of the
// auxiliary clock
// assumes oscillator outputs arrive as pins far below the 200 MHz
// system clock, and a classic wishbone master on the register side
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - after reset master and submain run from ring clock at 32x aux
// - aux clock is the first oscillator output, offered to peripherals
// - aux clock is also driven out divided by 1, 2, 4 or 8
// - master source picks first, second or ring oscillator clock
// - master clock may be divided by 1, 2, 4 or 8
// - submain source picks second or ring oscillator clock
// - range select bit 0 is watch crystal mode, 1 high frequency
// - second oscillator stops only when neither master nor submain use it
// - multiplier N is the low seven bits of the clock control register
// - ring clock is (N+1) times aux, or D times that when scaled
// - reset leaves scaling clear and loop divider at two
// - range bits decode by most significant set bit into five ranges
// - integrator of ten bits steps plus or minus one each aux period
// - integrator readable; upper five bits tap, lower five modulator
// - five-bit tap gives 29 taps, codes 28 to 31 equal
// - ring oscillator starts at lowest tap after reset or cleared integrator
// - one tap step takes 32 aux cycles of integrator movement
// - every control register may be rewritten at any time
// - loop disable freezes the integrator on its present tap
// - modulator mixes adjacent taps across a 32 ring clock window
module fcs_top
    import fcs_pkg::*;
#(
    parameter logic HAS_SECOND = 1'b1
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        first_osc_clock_i,
    input  wire logic        second_osc_clock_i,
    input  wire logic        ring_osc_raw_i,
    output logic             aux_clock_o,
    output logic             aux_div_clock_o,
    output logic             master_clock_o,
    output logic             submain_clock_o,
    output logic             ring_osc_clock_o,
    output logic             first_osc_enable_o,
    output logic             first_osc_hf_mode_o,
    output logic             second_osc_enable_o,
    output logic      [4:0]  tap_select_o,
    output logic      [2:0]  range_code_o
);

    // ==========================================================
    // registers
    logic [7:0] ctrl_ff;
    logic [7:0] lo_cfg_ff;
    logic [7:0] cfg_ff;
    logic [7:0] mode_ff;
    logic [9:0] integ;

    logic [6:0] mult_n;
    logic       mod_dis;
    fcs_div_e   loop_div;
    fcs_div_e   aux_div;
    fcs_div_e   mst_div;
    logic [1:0] msel;
    logic       ssel;
    logic       cpu_off;
    logic       loop_dis;
    logic       sm_off;

    assign mult_n   = ctrl_ff[6:0];
    assign mod_dis  = ctrl_ff[CTRL_MOD_DIS];
    assign loop_div = fcs_div_e'(lo_cfg_ff[LO_DIV_HI:LO_DIV_LO]);
    assign aux_div  = fcs_div_e'(cfg_ff[CFG_ADIV_LO+1:CFG_ADIV_LO]);
    assign mst_div  = fcs_div_e'(cfg_ff[CFG_MDIV_LO+1:CFG_MDIV_LO]);
    assign msel     = mode_ff[MODE_MSEL_LO+1:MODE_MSEL_LO];
    assign ssel     = mode_ff[MODE_SSEL];
    assign cpu_off  = mode_ff[MODE_CPU_OFF];
    assign loop_dis = mode_ff[MODE_LOOP_DIS];
    assign sm_off   = cfg_ff[CFG_SM_OFF];

    // ==========================================================
    // wishbone slave, one wait state, unmapped reads give zero
    logic       req;
    logic [7:0] idx;
    logic       wr_en;
    logic       wr_lo;
    logic       wr_hi;
    logic [7:0] rd_byte;

    assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign idx   = wb_adr_i[9:2];
    assign wr_en = req && wb_we_i && wb_sel_i[0] && (wb_adr_i[11:10] == 2'b00);
    assign wr_lo = wr_en && (idx == IDX_INT_LO);
    assign wr_hi = wr_en && (idx == IDX_INT_HI);

    always_comb begin
        rd_byte = 8'h00;
        if (wb_adr_i[11:10] != 2'b00) begin
            rd_byte = 8'h00;
        end else if (idx == IDX_INT_LO) begin
            rd_byte = {lo_cfg_ff[7:2], integ[1:0]};
        end else if (idx == IDX_INT_HI) begin
            rd_byte = integ[9:2];
        end else if (idx == IDX_CTRL) begin
            rd_byte = ctrl_ff;
        end else if (idx == IDX_CFG) begin
            rd_byte = cfg_ff;
        end else if (idx == IDX_MODE) begin
            rd_byte = mode_ff;
        end else if (idx == IDX_STAT) begin
            rd_byte = {!loop_dis, second_osc_enable_o, first_osc_enable_o, tap_select_o};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // ==========================================================
    // control register writes, accepted at any time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= RST_CTRL;
        end else if (wr_en && idx == IDX_CTRL) begin
            ctrl_ff <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lo_cfg_ff <= RST_INT_LO;
        end else if (wr_lo) begin
            lo_cfg_ff <= {wb_dat_i[7:2], 2'b00};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_ff <= RST_CFG;
        end else if (wr_en && idx == IDX_CFG) begin
            cfg_ff <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_ff <= RST_MODE;
        end else if (wr_en && idx == IDX_MODE) begin
            mode_ff <= wb_dat_i[7:0];
        end
    end

    // ==========================================================
    // pin synchronisers and edge detect on the second stage
    logic [2:0] x1_sync_ff;
    logic [2:0] x2_sync_ff;
    logic [2:0] rg_sync_ff;
    logic       x1_rise;
    logic       x2_rise;
    logic       rg_rise;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            x1_sync_ff <= 3'h0;
            x2_sync_ff <= 3'h0;
            rg_sync_ff <= 3'h0;
        end else begin
            x1_sync_ff <= {x1_sync_ff[1:0], first_osc_clock_i};
            x2_sync_ff <= {x2_sync_ff[1:0], second_osc_clock_i};
            rg_sync_ff <= {rg_sync_ff[1:0], ring_osc_raw_i};
        end
    end

    assign x1_rise = x1_sync_ff[1] && !x1_sync_ff[2];
    assign x2_rise = x2_sync_ff[1] && !x2_sync_ff[2];
    assign rg_rise = rg_sync_ff[1] && !rg_sync_ff[2];

    // ==========================================================
    // dividers
    logic loop_lvl;
    logic loop_rise;
    logic auxd_lvl;
    logic mst_lvl;
    logic rclk_lvl;
    logic rclk_rise;
    logic msrc_lvl;
    logic msrc_rise;

    // loop feedback always sees the raw ring clock divided by D
    fcs_divider u_loop_div (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .src_lvl_i  (rg_sync_ff[1]),
        .src_rise_i (rg_rise),
        .sel_i      (loop_div),
        .clk_o      (loop_lvl),
        .rise_o     (loop_rise)
    );

    fcs_divider u_aux_div (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .src_lvl_i  (x1_sync_ff[1]),
        .src_rise_i (x1_rise),
        .sel_i      (aux_div),
        .clk_o      (auxd_lvl),
        .rise_o     ()
    );

    // scaled mode passes the raw ring clock, so it runs D times faster
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rclk_lvl  <= 1'b0;
            rclk_rise <= 1'b0;
        end else if (cfg_ff[CFG_SCALE]) begin
            rclk_lvl  <= rg_sync_ff[2];
            rclk_rise <= rg_rise;
        end else begin
            rclk_lvl  <= loop_lvl;
            rclk_rise <= loop_rise;
        end
    end

    // ==========================================================
    // master source mux; absent second oscillator falls back to ring
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            msrc_lvl  <= 1'b0;
            msrc_rise <= 1'b0;
        end else if (msel == MSEL_FIRST) begin
            msrc_lvl  <= x1_sync_ff[2];
            msrc_rise <= x1_rise;
        end else if (msel == MSEL_SECOND && HAS_SECOND) begin
            msrc_lvl  <= x2_sync_ff[2];
            msrc_rise <= x2_rise;
        end else begin
            msrc_lvl  <= rclk_lvl;
            msrc_rise <= rclk_rise;
        end
    end

    fcs_divider u_mst_div (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .src_lvl_i  (msrc_lvl),
        .src_rise_i (msrc_rise),
        .sel_i      (mst_div),
        .clk_o      (mst_lvl),
        .rise_o     ()
    );

    // ==========================================================
    // clock outputs; processor off and submain off gate their clocks low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_clock_o      <= 1'b0;
            aux_div_clock_o  <= 1'b0;
            master_clock_o   <= 1'b0;
            submain_clock_o  <= 1'b0;
            ring_osc_clock_o <= 1'b0;
        end else begin
            aux_clock_o      <= x1_sync_ff[2];
            aux_div_clock_o  <= auxd_lvl;
            master_clock_o   <= mst_lvl && !cpu_off;
            ring_osc_clock_o <= rclk_lvl;
            if (sm_off) begin
                submain_clock_o <= 1'b0;
            end else if (ssel && HAS_SECOND) begin
                submain_clock_o <= x2_sync_ff[2];
            end else begin
                submain_clock_o <= rclk_lvl;
            end
        end
    end

    // ==========================================================
    // oscillator enables; a stop request is ignored while the
    // oscillator still feeds a running master or submain clock
    logic x1_in_use;
    logic x2_in_use;

    assign x1_in_use = (msel == MSEL_FIRST) && !cpu_off;
    assign x2_in_use = ((msel == MSEL_SECOND) && !cpu_off) || (ssel && !sm_off);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_osc_enable_o  <= 1'b1;
            second_osc_enable_o <= 1'b1;
            first_osc_hf_mode_o <= 1'b0;
            range_code_o        <= 3'h0;
        end else begin
            first_osc_enable_o  <= !(mode_ff[MODE_X1_OFF] && !x1_in_use);
            second_osc_enable_o <= HAS_SECOND && !(cfg_ff[CFG_X2_DIS] && !x2_in_use);
            first_osc_hf_mode_o <= cfg_ff[CFG_RANGE];
            range_code_o        <= fcs_range(lo_cfg_ff[LO_FN_HI:LO_FN_LO]);
        end
    end

    // ==========================================================
    // frequency comparison over each aux period
    logic [7:0] loop_cnt_ff;
    logic [7:0] target;
    logic       step;
    logic       step_up;

    assign target  = {1'b0, mult_n} + 8'h01;
    assign step    = x1_rise;
    // equal counts step down so the loop dithers around lock
    assign step_up = loop_cnt_ff < target;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            loop_cnt_ff <= 8'h00;
        end else if (x1_rise) begin
            loop_cnt_ff <= {7'h00, loop_rise};
        end else if (loop_rise && loop_cnt_ff != 8'hff) begin
            loop_cnt_ff <= loop_cnt_ff + 8'h01;
        end
    end

    // 32 integrator counts span one tap, so a tap step takes 32 aux cycles
    fcs_integrator u_integ (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .step_i  (step),
        .up_i    (step_up),
        .hold_i  (loop_dis),
        .wr_hi_i (wr_hi),
        .wr_lo_i (wr_lo),
        .wdata_i (wb_dat_i[7:0]),
        .value_o (integ)
    );

    // ==========================================================
    // modulator: window of 32 ring clocks, upper tap for mod of them
    logic [4:0] phase_ff;
    logic [4:0] base_tap;
    logic [4:0] mod_val;
    logic [5:0] mix_tap;

    assign base_tap = integ[9:5];
    assign mod_val  = integ[4:0];

    always_comb begin
        mix_tap = {1'b0, base_tap};
        if (mod_dis) begin
            mix_tap = {1'b0, base_tap} + {5'h00, mod_val[4]};
        end else if (phase_ff < mod_val) begin
            mix_tap = {1'b0, base_tap} + 6'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_ff <= 5'h00;
        end else if (rclk_rise) begin
            phase_ff <= phase_ff + 5'h01;
        end
    end

    // codes 28 to 31 share the top tap
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tap_select_o <= 5'h00;
        end else if (mix_tap > {1'b0, TAP_TOP}) begin
            tap_select_o <= TAP_TOP;
        end else begin
            tap_select_o <= mix_tap[4:0];
        end
    end

endmodule
`default_nettype wire

// ---- fcs_monitor.sv ----
// checker for the clock system register port and visible loop state
// assumes it is bound into fcs_top and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module fcs_monitor (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        first_osc_hf_mode_o,
    input wire logic [4:0]  tap_select_o,
    input wire logic [2:0]  range_code_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // handshake and visible state
    sequence take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence cfg_take;
        take ##0 (wb_we_i && wb_adr_i == 12'h14c && wb_sel_i[0]);
    endsequence
    a_ack_next: assert property (take |=> wb_ack_o) else $error("ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
    // status read must carry the tap that stood when the request was taken
    a_stat_tap: assert property (take ##0 (!wb_we_i && wb_adr_i == 12'h154) |=>
        wb_dat_o[4:0] == $past(tap_select_o)) else $error("status tap");
    a_hf_follow: assert property (cfg_take |-> ##3 first_osc_hf_mode_o == $past(wb_dat_i[0], 3))
        else $error("hf mode");
    a_tap_clamp: assert property (tap_select_o <= 5'h1c) else $error("tap above top");
    a_range_max: assert property (range_code_o <= 3'h4) else $error("range code");
    a_reset_state: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i ##1 rst_i |-> tap_select_o == 5'h0 && !wb_ack_o) else $error("reset state");
endmodule
bind fcs_top fcs_monitor u_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .first_osc_hf_mode_o, .tap_select_o, .range_code_o);
`default_nettype wire

// ---- fcs_osc_model.sv ----
// pin model: two crystals and a ring oscillator speeding up with tap
// assumes all pin edges are timed from the system clock
`timescale 1ns/1ps
`default_nettype none
module fcs_osc_model #(
    parameter int HALF1 = 150,
    parameter int HALF2 = 25
) (
    input  wire logic       clk_i,
    input  wire logic       en1_i,
    input  wire logic       en2_i,
    input  wire logic [4:0] tap_i,
    output logic            x1_o,
    output logic            x2_o,
    output logic            ring_o
);
    int c1 = 0;
    int c2 = 0;
    int c3 = 0;
    initial begin
        x1_o = 1'b0;
        x2_o = 1'b0;
        ring_o = 1'b0;
    end
    // ==========================================================
    // a disabled crystal falls silent low instead of running on
    always @(posedge clk_i) begin
        c1 <= (c1 + 1 >= HALF1) ? 0 : c1 + 1;
        c2 <= (c2 + 1 >= HALF2) ? 0 : c2 + 1;
        c3 <= (c3 + 1 >= 60 - 2 * int'(tap_i)) ? 0 : c3 + 1;
        if (c1 + 1 >= HALF1) x1_o <= en1_i && !x1_o;
        if (c2 + 1 >= HALF2) x2_o <= en2_i && !x2_o;
        if (c3 + 1 >= 60 - 2 * int'(tap_i)) ring_o <= !ring_o;
    end
endmodule
`default_nettype wire

// ---- fcs_top_tb_top.sv ----
// bench for the clock system: registers, source periods, integrator
// assumes fcs_osc_model drives the oscillator pins
`timescale 1ns/1ps
`default_nettype none
module fcs_top_tb_top;
    import fcs_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [11:0] adr = 12'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dw = 32'h0;
    logic [31:0] dr, q, v1, v2;
    logic        ack, p1, p2, pr, aux, auxd, mclk, submain_clock, rclk, e1, hf, e2, mon;
    logic [4:0]  tap;
    logic [2:0]  rng;
    logic [31:0] exp_q[$];
    int          n_fail = 0, samples_checked = 0, msel = 0, p;
    always #2.5 clk_i = ~clk_i;
    fcs_top u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .first_osc_clock_i(p1),
        .second_osc_clock_i(p2), .ring_osc_raw_i(pr), .aux_clock_o(aux), .aux_div_clock_o(auxd),
        .master_clock_o(mclk), .submain_clock_o(submain_clock), .ring_osc_clock_o(rclk), .first_osc_enable_o(e1),
        .first_osc_hf_mode_o(hf), .second_osc_enable_o(e2), .tap_select_o(tap), .range_code_o(rng));
    fcs_osc_model u_osc (.clk_i, .en1_i(e1), .en2_i(e2), .tap_i(tap), .x1_o(p1), .x2_o(p2), .ring_o(pr));
    // ==========================================================
    // helpers
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task bus(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {2'b00, idx, 2'b00};
        dw <= {24'h0, d};
        sel <= s;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'hf);
    endtask
    task rd(input logic [7:0] idx, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(1'b0, idx, 8'h0, 4'hf);
    endtask
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) chk("read data", dr, exp_q.pop_front());
    end
    always_comb begin
        case (msel)
            0: mon = auxd;
            1: mon = mclk;
            2: mon = submain_clock;
            4: mon = aux;
            default: mon = rclk;
        endcase
    end
    // skips two rises so a divider that was just reprogrammed has settled
    task per(input int m, output int pd);
        int c;
        int r;
        logic l;
        c = 0;
        r = 0;
        l = 1'b1;
        msel = m;
        while (r < 4 && c < 20000) begin
            @(posedge clk_i);
            c++;
            if (!l && mon && ++r == 3) c = 0;
            l = mon;
        end
        pd = (r == 4) ? c : 0;
    endtask
    // reads land well clear of the next integrator step
    task rint(input int k, output logic [31:0] v);
        logic l;
        l = aux;
        while (k > 0) begin
            @(posedge clk_i);
            if (!l && aux) k--;
            l = aux;
        end
        repeat (20) @(posedge clk_i);
        bus(1'b0, IDX_INT_HI, 8'h0, 4'hf);
        v = {22'h0, q[7:0], 2'b00};
        bus(1'b0, IDX_INT_LO, 8'h0, 4'hf);
        v[1:0] = q[1:0];
    endtask
    // ==========================================================
    // tests
    initial begin
        void'($urandom(32'h1af0));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(IDX_CTRL, RST_CTRL);
        rd(IDX_INT_LO, RST_INT_LO);
        rd(IDX_INT_HI, RST_INT_HI);
        rd(IDX_CFG, RST_CFG);
        rd(IDX_MODE, RST_MODE);
        rd(8'h40, 8'h00);
        rd(IDX_STAT, 8'he0);
        bus(1'b1, IDX_CTRL, 8'h00, 4'he);
        rd(IDX_CTRL, RST_CTRL);
        wr(IDX_MODE, 8'h04);
        for (int i = 0; i < 4; i++) begin
            v1 = $urandom;
            wr(IDX_CTRL, v1[7:0]);
            rd(IDX_CTRL, v1[7:0]);
        end
        $display("test registers done");
        wr(IDX_INT_HI, 8'hf8);
        wr(IDX_INT_LO, 8'h40);
        chk("tap", tap, 32'd28);
        wr(IDX_INT_HI, 8'h00);
        repeat (2) @(posedge clk_i);
        chk("tap", tap, 32'd0);
        wr(IDX_INT_HI, 8'h40);
        repeat (2) @(posedge clk_i);
        chk("tap", tap, 32'd8);
        per(3, p);
        chk("ring period", p, 32'd176);
        per(1, p);
        chk("master period", p, 32'd176);
        per(2, p);
        chk("submain period", p, 32'd176);
        wr(IDX_CFG, 8'h02);
        per(3, p);
        chk("ring period", p, 32'd88);
        rint(1, v1);
        rint(10, v2);
        chk("frozen integrator", v2, v1);
        wr(IDX_CFG, 8'h00);
        wr(IDX_CTRL, 8'h07);
        wr(IDX_MODE, 8'h00);
        rint(1, v1);
        rint(10, v2);
        chk("integrator rise", v2 - v1, 32'd10);
        wr(IDX_CTRL, 8'h00);
        rint(1, v1);
        rint(10, v2);
        chk("integrator fall", v1 - v2, 32'd10);
        $display("test loop done");
        wr(IDX_MODE, 8'h04);
        for (int i = 0; i < 5; i++) begin
            v1 = (i == 0) ? 0 : ((1 << (i - 1)) | ($urandom & ((1 << (i - 1)) - 1)));
            wr(IDX_INT_LO, 8'h40 | (v1[7:0] << 2));
            rd(IDX_INT_LO, 8'h40 | (v1[7:0] << 2));
            chk("range", rng, i);
        end
        wr(IDX_MODE, 8'h34);
        per(4, p);
        chk("aux period", p, 32'd300);
        for (int k = 0; k < 4; k++) begin
            wr(IDX_CFG, 8'(k * 20));
            per(0, p);
            chk("aux out period", p, 300 << k);
            per(1, p);
            chk("master period", p, 300 << k);
        end
        $display("test dividers done");
        wr(IDX_CFG, 8'h01);
        chk("hf mode", hf, 32'd1);
        wr(IDX_MODE, 8'h24);
        per(1, p);
        chk("master period", p, 32'd50);
        wr(IDX_CFG, 8'h41);
        chk("second enable", e2, 32'd1);
        wr(IDX_MODE, 8'h44);
        per(2, p);
        chk("submain period", p, 32'd50);
        wr(IDX_MODE, 8'h04);
        chk("second enable", e2, 32'd0);
        wr(IDX_MODE, 8'h36);
        chk("first enable", e1, 32'd1);
        wr(IDX_MODE, 8'h06);
        chk("first enable", e1, 32'd0);
        $display("test sources done");
        conclude();
    end
    initial begin
        repeat (100000) @(posedge clk_i);
        n_fail++;
        conclude();
    end
endmodule
`default_nettype wire
